// *** hw/spra_fmem.v ***
module spra_fmem (
	// clock and reset
	input  wire        clk_in,
	input  wire        rst_n_in,
	// write port
	input  wire        we_in,
	input  wire [2:0]  wa_in,
	input  wire [23:0] wd_in,
	// registered read port
	input  wire [2:0]  ra_in,
	output reg  [23:0] rd_out
);

	// ****************************************
	// meter function values
	// ****************************************
	wire [23:0] word [0:7];

	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_word
			reg [23:0] val_q;
			always @(posedge clk_in) begin
				if (!rst_n_in) begin
					val_q <= 24'h00_0000;
				end else if (we_in && wa_in == i) begin
					val_q <= wd_in;
				end
			end
			assign word[i] = val_q;
		end
	endgenerate

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			rd_out <= 24'h00_0000;
		end else begin
			rd_out <= word[ra_in];
		end
	end

endmodule

// *** hw/spra_map.vh ***
// Contract
// - an enable bit switches the whole trigger-and-reset function off.
// - trigger both acts on every relay make and every relay break.
// - trigger level acts once per sample period while the relay is on.
// - target off disables reset, hides mode and constant, flags return step.
// - store-constant mode writes the constant into the target function.
// - overshoot mode writes activation value minus setpoint plus constant.
// - add mode writes target value plus the signed constant.
// - copy mode writes the chosen source function into the target.
// - constant is signed, clamped to -199999..999999, resets to zero.
// - in copy mode the constant is hidden and, unless target is off, a source select shows.
// - setpoint activation value resets to 180000 counts.
// - while lock input is grounded, settings read back but their writes drop; function value writes still land.
// - grounded total one clear input clears totalizer one to zero.
// - grounded total two clear input clears totalizer two to zero.
// - a switch chosen in code digit two overrides the configured source.
// - digit two at zero activates from the configured source.
`ifndef SPRA_MAP_VH
`define SPRA_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define SPRA_ADR_CTRL      8'h00
`define SPRA_ADR_CODE      8'h04
`define SPRA_ADR_SETPT     8'h08
`define SPRA_ADR_CONST     8'h0C
`define SPRA_ADR_STAT      8'h10
`define SPRA_FUNC_PAGE     3'h1

// ****************************************
// control register field positions
// ****************************************
`define SPRA_F_EN          0
`define SPRA_F_TRIG        1
`define SPRA_F_RESET_TARGET        3
`define SPRA_F_MODE        6
`define SPRA_F_CSRC        8
`define SPRA_F_ASRC        12

// ****************************************
// encodings
// ****************************************
`define SPRA_TRIG_MAKE     2'h0
`define SPRA_TRIG_BREAK    2'h1
`define SPRA_TRIG_BOTH     2'h2
`define SPRA_TRIG_LEVEL    2'h3
`define SPRA_MODE_CONST    2'h0
`define SPRA_MODE_ISC      2'h1
`define SPRA_MODE_DPC      2'h2
`define SPRA_MODE_COPY     2'h3
`define SPRA_RESET_TARGET_OFF      3'h0
`define SPRA_FN_TOT1       3'h1
`define SPRA_FN_TOT2       3'h2
`define SPRA_EXT_NONE      4'h0
`define SPRA_EXT_LOCK      4'h1
`define SPRA_EXT_TOT1      4'h2
`define SPRA_EXT_TOT2      4'h3

// ****************************************
// reset values and limits
// ****************************************
`define SPRA_SETPT_RST     24'h02_BF20
`define SPRA_CONST_RST     24'h00_0000
`define SPRA_CONST_MIN     32'hFFFC_F2C1
`define SPRA_CONST_MAX     32'h000F_423F

// ****************************************
// timing
// ****************************************
`define SPRA_CLK_PERIOD_NS     4
`define SPRA_SAMPLE_PERIOD_NS  20000000

`endif

// *** hw/spra_sync.v ***
module spra_sync (
	// clock and reset
	input  wire       clk_in,
	input  wire       rst_n_in,
	// raw pins and settled levels
	input  wire [2:0] pin_in,
	output wire [2:0] level_out
);

	// ****************************************
	// three stage synchronisers per pin
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_bit
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg lvl_q;
			always @(posedge clk_in) begin
				if (!rst_n_in) begin
					s1_q  <= 1'b1;
					s2_q  <= 1'b1;
					s3_q  <= 1'b1;
					lvl_q <= 1'b1;
				end else begin
					s1_q <= pin_in[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						lvl_q <= s3_q;
					end
				end
			end
			assign level_out[i] = lvl_q;
		end
	endgenerate

endmodule

// *** hw/spra_top.v ***
`include "spra_map.vh"

module spra_top #(
	parameter SAMPLE_CYCLES =
		`SPRA_SAMPLE_PERIOD_NS / `SPRA_CLK_PERIOD_NS
) (
	// clock and reset
	input  wire        REF_CLK_IN,
	input  wire        RST_N_IN,
	// wishbone slave
	input  wire        WB_CYC_IN,
	input  wire        WB_STB_IN,
	input  wire        WB_WE_IN,
	input  wire [7:0]  WB_ADR_IN,
	input  wire [3:0]  WB_SEL_IN,
	input  wire [31:0] WB_DAT_IN,
	output wire [31:0] WB_DAT_OUT,
	output wire        WB_ACK_OUT,
	// contact closure pins, grounded when active
	input  wire        LOCK_N_IN,
	input  wire        TOTAL_ONE_CLEAR_N_IN,
	input  wire        TOTAL_TWO_CLEAR_N_IN,
	// relay and action strobe
	output wire        RELAY_OUT,
	output wire        RESET_DONE_OUT
);

	localparam [1:0]  ST_IDLE   = 2'h0;
	localparam [1:0]  ST_EVAL   = 2'h1;
	localparam [1:0]  ST_WR     = 2'h2;
	localparam [22:0] TICK_LAST = SAMPLE_CYCLES[22:0] - 23'h00_0001;

	// ****************************************
	// pin inputs
	// ****************************************
	wire [2:0] pin_lvl;

	spra_sync u_sync (
		.clk_in    (REF_CLK_IN),
		.rst_n_in  (RST_N_IN),
		.pin_in    ({TOTAL_TWO_CLEAR_N_IN, TOTAL_ONE_CLEAR_N_IN, LOCK_N_IN}),
		.level_out (pin_lvl)
	);

	wire lock_on = ~pin_lvl[0];
	wire tot1_on = ~pin_lvl[1];
	wire tot2_on = ~pin_lvl[2];

	// ****************************************
	// sample period tick
	// ****************************************
	reg [22:0] div_q;
	reg        tick_q;

	always @(posedge REF_CLK_IN) begin
		if (!RST_N_IN) begin
			div_q  <= 23'h00_0000;
			tick_q <= 1'b0;
		end else if (div_q == TICK_LAST) begin
			div_q  <= 23'h00_0000;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 23'h00_0001;
			tick_q <= 1'b0;
		end
	end

	// ****************************************
	// state and settings
	// ****************************************
	reg [1:0]  st_q;
	reg        start_q;
	reg        clr1_q;
	reg        clr2_q;
	reg        stage_q;
	reg        ack_q;
	reg [31:0] dat_q;
	reg        relay_q;
	reg        done_q;
	reg [7:0]  count_q;
	reg [23:0] act_q;
	reg        en_q;
	reg [1:0]  trig_q;
	reg [2:0]  reset_target_q;
	reg [1:0]  mode_q;
	reg [2:0]  csrc_q;
	reg [2:0]  asrc_q;
	reg [11:0] code_q;
	reg [23:0] setpt_q;
	reg [23:0] const_q;

	wire [23:0] mem_rd;
	reg  [2:0]  mem_ra;
	reg         mem_we;
	reg  [2:0]  mem_wa;
	reg  [23:0] mem_wd;

	spra_fmem u_fmem (
		.clk_in   (REF_CLK_IN),
		.rst_n_in (RST_N_IN),
		.we_in    (mem_we),
		.wa_in    (mem_wa),
		.wd_in    (mem_wd),
		.ra_in    (mem_ra),
		.rd_out   (mem_rd)
	);

	// ****************************************
	// bus decode
	// ****************************************
	wire       bus_req  = WB_CYC_IN & WB_STB_IN & ~ack_q & ~stage_q;
	wire       is_func  = (WB_ADR_IN[7:5] == `SPRA_FUNC_PAGE);
	wire [2:0] fidx     = WB_ADR_IN[4:2];
	wire       bus_wr   = stage_q & WB_WE_IN;
	wire       cfg_wr   = bus_wr & ~lock_on;
	wire       reset_target_off = (reset_target_q == `SPRA_RESET_TARGET_OFF);
	wire       is_copy  = (mode_q == `SPRA_MODE_COPY);
	wire       idle     = (st_q == ST_IDLE);

	function [31:0] merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  sel;
		integer b;
		begin
			merge = old_v;
			for (b = 0; b < 4; b = b + 1) begin
				if (sel[b]) begin
					merge[b*8 +: 8] = new_v[b*8 +: 8];
				end
			end
		end
	endfunction

	wire [31:0] fn_old    = {{8{mem_rd[23]}}, mem_rd};
	wire [31:0] fn_new    = merge(fn_old, WB_DAT_IN, WB_SEL_IN);
	wire [31:0] sp_new    = merge({{8{setpt_q[23]}}, setpt_q},
		WB_DAT_IN, WB_SEL_IN);
	wire [31:0] cn_raw    = merge({{8{const_q[23]}}, const_q},
		WB_DAT_IN, WB_SEL_IN);
	wire [31:0] ctl_new   = merge({16'h0000, 1'b0, asrc_q, 1'b0, csrc_q,
		mode_q, reset_target_q, trig_q, en_q}, WB_DAT_IN, WB_SEL_IN);
	wire [31:0] code_new  = merge({20'h0_0000, code_q}, WB_DAT_IN, WB_SEL_IN);

	// constant saturates into its legal range
	wire [31:0] cn_clamp =
		($signed(cn_raw) < $signed(`SPRA_CONST_MIN)) ? `SPRA_CONST_MIN :
		($signed(cn_raw) > $signed(`SPRA_CONST_MAX)) ? `SPRA_CONST_MAX :
		cn_raw;

	// ****************************************
	// activation and trigger decision
	// ****************************************
	wire [3:0] digit2 = code_q[7:4];
	reg        relay_new;

	always @* begin
		case (digit2)
			`SPRA_EXT_LOCK: relay_new = lock_on;
			`SPRA_EXT_TOT1: relay_new = tot1_on;
			`SPRA_EXT_TOT2: relay_new = tot2_on;
			default: relay_new = ($signed(mem_rd) >= $signed(setpt_q));
		endcase
	end

	wire make_edge = ~relay_q & relay_new;
	wire brk_edge  = relay_q & ~relay_new;
	reg  edge_hit;

	always @* begin
		case (trig_q)
			`SPRA_TRIG_MAKE:  edge_hit = make_edge;
			`SPRA_TRIG_BREAK: edge_hit = brk_edge;
			`SPRA_TRIG_BOTH:  edge_hit = make_edge | brk_edge;
			`SPRA_TRIG_LEVEL: edge_hit = relay_new;
			default:          edge_hit = 1'b0;
		endcase
	end

	wire fire = en_q & ~reset_target_off & edge_hit;

	// ****************************************
	// new target value
	// ****************************************
	reg [23:0] result;

	always @* begin
		case (mode_q)
			`SPRA_MODE_CONST: result = const_q;
			`SPRA_MODE_ISC:   result = act_q - setpt_q + const_q;
			`SPRA_MODE_DPC:   result = mem_rd + const_q;
			`SPRA_MODE_COPY:  result = mem_rd;
			default:          result = const_q;
		endcase
	end

	// ****************************************
	// function memory port steering
	// ****************************************
	always @* begin
		mem_ra = fidx;
		mem_we = 1'b0;
		mem_wa = fidx;
		mem_wd = fn_new[23:0];
		case (st_q)
			ST_IDLE: begin
				if (stage_q) begin
					mem_we = bus_wr & is_func;
				end else if (clr1_q) begin
					mem_we = 1'b1;
					mem_wa = `SPRA_FN_TOT1;
					mem_wd = 24'h00_0000;
				end else if (clr2_q) begin
					mem_we = 1'b1;
					mem_wa = `SPRA_FN_TOT2;
					mem_wd = 24'h00_0000;
				end else if (start_q) begin
					mem_ra = asrc_q;
				end
			end
			ST_EVAL: begin
				mem_ra = is_copy ? csrc_q : reset_target_q;
			end
			ST_WR: begin
				mem_we = 1'b1;
				mem_wa = reset_target_q;
				mem_wd = result;
			end
			default: begin
				mem_ra = fidx;
			end
		endcase
	end

	wire busy_idle = stage_q | clr1_q | clr2_q | start_q;
	wire take_clr1 = idle & ~stage_q & clr1_q;
	wire take_clr2 = idle & ~stage_q & ~clr1_q & clr2_q;
	wire take_st   = idle & ~stage_q & ~clr1_q & ~clr2_q & start_q;
	wire accept    = idle & ~busy_idle & bus_req;

	// ****************************************
	// read data
	// ****************************************
	reg [31:0] rd_val;

	always @* begin
		rd_val = 32'h0000_0000;
		if (is_func) begin
			rd_val = fn_old;
		end else begin
			case (WB_ADR_IN)
				`SPRA_ADR_CTRL: rd_val = {16'h0000, 1'b0, asrc_q, 1'b0,
					(is_copy & ~reset_target_off) ? csrc_q : 3'h0,
					reset_target_off ? 2'h0 : mode_q, reset_target_q, trig_q, en_q};
				`SPRA_ADR_CODE:  rd_val = {20'h0_0000, code_q};
				`SPRA_ADR_SETPT: rd_val = {{8{setpt_q[23]}}, setpt_q};
				`SPRA_ADR_CONST: rd_val = (reset_target_off | is_copy) ? 32'h0000_0000 :
					{{8{const_q[23]}}, const_q};
				`SPRA_ADR_STAT:  rd_val = {16'h0000, count_q, 2'h0, reset_target_off,
					~idle, tot2_on, tot1_on, lock_on, relay_q};
				default:         rd_val = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// sequencing and registers
	// ****************************************
	always @(posedge REF_CLK_IN) begin
		if (!RST_N_IN) begin
			st_q    <= ST_IDLE;
			start_q <= 1'b0;
			clr1_q  <= 1'b0;
			clr2_q  <= 1'b0;
			stage_q <= 1'b0;
			ack_q   <= 1'b0;
			dat_q   <= 32'h0000_0000;
			relay_q <= 1'b0;
			done_q  <= 1'b0;
			count_q <= 8'h00;
			act_q   <= 24'h00_0000;
			en_q    <= 1'b0;
			trig_q  <= `SPRA_TRIG_MAKE;
			reset_target_q  <= `SPRA_RESET_TARGET_OFF;
			mode_q  <= `SPRA_MODE_CONST;
			csrc_q  <= 3'h0;
			asrc_q  <= 3'h0;
			code_q  <= 12'h000;
			setpt_q <= `SPRA_SETPT_RST;
			const_q <= `SPRA_CONST_RST;
		end else begin
			// a new tick wins over the take of the previous request
			start_q <= tick_q | (start_q & ~take_st);
			clr1_q  <= (tick_q & tot1_on) | (clr1_q & ~take_clr1);
			clr2_q  <= (tick_q & tot2_on) | (clr2_q & ~take_clr2);
			stage_q <= accept;
			ack_q   <= stage_q;
			done_q  <= 1'b0;
			if (stage_q) begin
				dat_q <= WB_WE_IN ? 32'h0000_0000 : rd_val;
			end
			if (cfg_wr && WB_ADR_IN == `SPRA_ADR_CTRL) begin
				en_q   <= ctl_new[`SPRA_F_EN];
				trig_q <= ctl_new[`SPRA_F_TRIG+1:`SPRA_F_TRIG];
				reset_target_q <= ctl_new[`SPRA_F_RESET_TARGET+2:`SPRA_F_RESET_TARGET];
				mode_q <= ctl_new[`SPRA_F_MODE+1:`SPRA_F_MODE];
				csrc_q <= ctl_new[`SPRA_F_CSRC+2:`SPRA_F_CSRC];
				asrc_q <= ctl_new[`SPRA_F_ASRC+2:`SPRA_F_ASRC];
			end
			if (cfg_wr && WB_ADR_IN == `SPRA_ADR_CODE) begin
				code_q <= code_new[11:0];
			end
			if (cfg_wr && WB_ADR_IN == `SPRA_ADR_SETPT) begin
				setpt_q <= sp_new[23:0];
			end
			if (cfg_wr && WB_ADR_IN == `SPRA_ADR_CONST && !reset_target_off
				&& !is_copy) begin
				const_q <= cn_clamp[23:0];
			end
			case (st_q)
				ST_IDLE: begin
					if (take_st) begin
						st_q <= ST_EVAL;
					end
				end
				ST_EVAL: begin
					act_q   <= mem_rd;
					relay_q <= relay_new;
					st_q    <= fire ? ST_WR : ST_IDLE;
				end
				ST_WR: begin
					done_q  <= 1'b1;
					count_q <= count_q + 8'h01;
					st_q    <= ST_IDLE;
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign WB_DAT_OUT     = dat_q;
	assign WB_ACK_OUT     = ack_q;
	assign RELAY_OUT      = relay_q;
	assign RESET_DONE_OUT = done_q;

endmodule

// *** verif/spra_chk_assertions.sv ***
module spra_chk #(
	parameter SAMPLE_CYCLES = 64
) (
	// clock and reset
	input wire        REF_CLK_IN,
	input wire        RST_N_IN,
	// wishbone
	input wire        WB_CYC_IN,
	input wire        WB_STB_IN,
	input wire        WB_WE_IN,
	input wire [7:0]  WB_ADR_IN,
	input wire [31:0] WB_DAT_OUT,
	input wire        WB_ACK_OUT,
	// relay and action strobe
	input wire        RELAY_OUT,
	input wire        RESET_DONE_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// cycles since the relay last moved
	// ****************
	logic [31:0] rel_age_q;
	always @(posedge REF_CLK_IN) begin
		if (!RST_N_IN)
			rel_age_q <= 32'hFFFF_FFFF;
		else if ($changed(RELAY_OUT))
			rel_age_q <= 32'h0000_0000;
		else if (rel_age_q != 32'hFFFF_FFFF)
			rel_age_q <= rel_age_q + 32'h0000_0001;
	end
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	sequence req_s;
		$rose(WB_STB_IN) && WB_CYC_IN;
	endsequence
	sequence ans_s;
		##[1:12] WB_ACK_OUT;
	endsequence
	ack_bound_a: assert property (req_s |-> ans_s)
		else $error("bus request not answered");
	ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (WB_ACK_OUT |->
		WB_CYC_IN && WB_STB_IN && $past(WB_STB_IN))
		else $error("ack without a request");
	unmapped_zero_a: assert property (WB_ACK_OUT && !WB_WE_IN &&
		WB_ADR_IN == 8'h18 |-> WB_DAT_OUT == 32'h0000_0000)
		else $error("unmapped read not zero");
	quiet_start_a: assert property ($rose(RST_N_IN) |->
		!WB_ACK_OUT && !RELAY_OUT && !RESET_DONE_OUT)
		else $error("outputs active after reset");
	done_pulse_a: assert property (
		RESET_DONE_OUT |=> !RESET_DONE_OUT)
		else $error("action strobe too long");
	done_cause_a: assert property (
		RESET_DONE_OUT |-> RELAY_OUT || rel_age_q < 16)
		else $error("action with relay idle");
	relay_tick_a: assert property (
		$changed(RELAY_OUT) |-> rel_age_q > SAMPLE_CYCLES / 2)
		else $error("relay moved twice in a period");
endmodule

bind spra_top spra_chk #(
	.SAMPLE_CYCLES(SAMPLE_CYCLES)
) u_spra_chk (
	.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
	.WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
	.RELAY_OUT(RELAY_OUT), .RESET_DONE_OUT(RESET_DONE_OUT)
);

// *** verif/spra_switches.sv ***
module spra_switches (
	// closures asked for by the bench
	input  wire close_lock_in,
	input  wire close_one_in,
	input  wire close_two_in,
	// pins, pulled up while open
	output wire lock_n_out,
	output wire one_clear_n_out,
	output wire two_clear_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// contacts only ever ground a pin
	// ****************
	assign lock_n_out      = close_lock_in ? 1'b0 : 1'b1;
	assign one_clear_n_out = close_one_in ? 1'b0 : 1'b1;
	assign two_clear_n_out = close_two_in ? 1'b0 : 1'b1;
endmodule

// *** verif/tb_top.sv ***
`define CHK(g, e) \
	begin \
		total_checks++; \
		if ((g) !== (e)) begin \
			n_fail++; \
			$display("[FAIL] %0t got %h want %h", $time, g, e); \
		end \
	end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 64;
	localparam logic [31:0] F = 32'hFFFF_FFFF;
	localparam logic [31:0] Z = 32'h0000_0000;
	localparam logic [31:0] BASE = 32'h0000_3526;
	typedef struct packed {
		logic        we;
		logic [7:0]  adr;
		logic [31:0] dat;
		logic [31:0] msk;
	} spra_row_t;
	spra_row_t rows [18] = '{
		'{1'b0, 8'h08, 32'h0002_BF20, F},
		'{1'b0, 8'h0C, Z, F},
		'{1'b0, 8'h00, Z, F},
		'{1'b0, 8'h10, 32'h0000_0020, 32'h0000_FF20},
		'{1'b1, 8'h00, 32'h0000_000E, F},
		'{1'b0, 8'h10, Z, 32'h0000_0020},
		'{1'b1, 8'h0C, 32'h00F4_2400, F},
		'{1'b0, 8'h0C, 32'h000F_423F, F},
		'{1'b1, 8'h0C, 32'hFFFC_F2C0, F},
		'{1'b0, 8'h0C, 32'hFFFC_F2C1, F},
		'{1'b1, 8'h00, 32'h0000_02CE, F},
		'{1'b0, 8'h00, 32'h0000_02CE, F},
		'{1'b0, 8'h0C, Z, F},
		'{1'b1, 8'h00, 32'h0000_02C1, F},
		'{1'b0, 8'h00, 32'h0000_0001, F},
		'{1'b0, 8'h0C, Z, F},
		'{1'b1, 8'h18, 32'h1234_5678, F},
		'{1'b0, 8'h18, Z, F}
	};
	logic [31:0] exp_m [4] = '{32'h0000_0005, 32'h0000_000A,
		32'h0000_0069, 32'h0000_002A};
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic        cl = 1'b0;
	logic        c1 = 1'b0;
	logic        c2 = 1'b0;
	wire         lock_n;
	wire         t1_n;
	wire         t2_n;
	wire [31:0]  rdat;
	wire         ack;
	wire         relay;
	wire         done;
	int          n_fail = 0;
	int          total_checks = 0;
	int          n_done = 0;
	int          d0 = 0;

	spra_top #(.SAMPLE_CYCLES(SC)) u_spra_top (
		.REF_CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc),
		.WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
		.WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .LOCK_N_IN(lock_n),
		.TOTAL_ONE_CLEAR_N_IN(t1_n), .TOTAL_TWO_CLEAR_N_IN(t2_n),
		.RELAY_OUT(relay), .RESET_DONE_OUT(done)
	);
	spra_switches u_spra_switches (
		.close_lock_in(cl), .close_one_in(c1), .close_two_in(c2),
		.lock_n_out(lock_n), .one_clear_n_out(t1_n),
		.two_clear_n_out(t2_n)
	);

	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (done === 1'b1)
			n_done <= n_done + 1;
	end
	// ****************
	// bus cycles and closing
	// ****************
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] v, output logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= v;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		d = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 40)
			n_fail++;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] d;
		bus(1'b1, a, v, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = F);
		logic [31:0] d;
		bus(1'b0, a, Z, d);
		`CHK(d & m, e & m)
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		while (n_done == d0 && n < 2 * SC) begin
			@(posedge clk);
			n++;
		end
		`CHK(n_done != d0, 1'b1)
	endtask
	task automatic results();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		results();
	end
	// ****************
	// table, then hand-written cases
	// ****************
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHK({ack, relay, done}, 3'b000)
		foreach (rows[i]) begin
			if (rows[i].we)
				wr(rows[i].adr, rows[i].dat);
			else
				rdc(rows[i].adr, rows[i].dat, rows[i].msk);
		end
		cl <= 1'b1;
		repeat (8) @(posedge clk);
		wr(8'h08, 32'h0000_000A);
		rdc(8'h08, 32'h0002_BF20);
		cl <= 1'b0;
		repeat (8) @(posedge clk);
		wr(8'h24, 32'h0000_004D);
		wr(8'h28, 32'h0000_0058);
		c1 <= 1'b1;
		repeat (SC + 20) @(posedge clk);
		rdc(8'h24, Z);
		rdc(8'h28, 32'h0000_0058);
		c1 <= 1'b0;
		c2 <= 1'b1;
		repeat (SC + 20) @(posedge clk);
		rdc(8'h28, Z);
		c2 <= 1'b0;
		wr(8'h08, 32'h0000_000A);
		wr(8'h2C, 32'h0000_000F);
		wr(8'h34, 32'h0000_002A);
		wr(8'h00, BASE);
		wr(8'h0C, 32'h0000_0005);
		for (int m = 0; m < 4; m++) begin
			wr(8'h30, 32'h0000_0064);
			d0 = n_done;
			wr(8'h00, BASE | (32'(m) << 6) | 32'h0000_0001);
			wait_done();
			wr(8'h00, BASE);
			rdc(8'h30, exp_m[m]);
		end
		d0 = n_done;
		repeat (2 * SC) @(posedge clk);
		`CHK(n_done, d0)
		wr(8'h00, BASE | 32'h0000_0001);
		d0 = n_done;
		repeat (3 * SC) @(posedge clk);
		`CHK(n_done - d0, 3)
		wr(8'h00, 32'h0000_3007);
		d0 = n_done;
		repeat (2 * SC) @(posedge clk);
		`CHK(n_done, d0)
		wr(8'h04, 32'h0000_0020);
		repeat (SC + 20) @(posedge clk);
		`CHK(relay, 1'b0)
		wr(8'h30, Z);
		wr(8'h00, 32'h0000_35A5);
		d0 = n_done;
		c1 <= 1'b1;
		repeat (SC + 20) @(posedge clk);
		`CHK(relay, 1'b1)
		c1 <= 1'b0;
		repeat (SC + 20) @(posedge clk);
		`CHK(relay, 1'b0)
		wr(8'h04, Z);
		repeat (SC + 20) @(posedge clk);
		`CHK(relay, 1'b1)
		`CHK(n_done - d0, 3)
		rdc(8'h30, 32'h0000_000F);
		d0 = n_done;
		wr(8'h00, 32'h0000_35A1);
		wr(8'h04, 32'h0000_0010);
		repeat (SC + 20) @(posedge clk);
		`CHK(relay, 1'b0)
		`CHK(n_done, d0)
		cl <= 1'b1;
		repeat (SC + 20) @(posedge clk);
		`CHK(relay, 1'b1)
		`CHK(n_done - d0, 1)
		cl <= 1'b0;
		repeat (SC + 20) @(posedge clk);
		`CHK(relay, 1'b0)
		`CHK(n_done - d0, 1)
		wr(8'h00, 32'h0000_35A3);
		wr(8'h04, 32'h0000_0030);
		c2 <= 1'b1;
		repeat (SC + 20) @(posedge clk);
		`CHK(relay, 1'b1)
		`CHK(n_done - d0, 1)
		c2 <= 1'b0;
		repeat (SC + 20) @(posedge clk);
		`CHK(relay, 1'b0)
		`CHK(n_done - d0, 2)
		rdc(8'h30, 32'h0000_0019);
		results();
	end
endmodule
